// ==== vbf_pkg.sv ====
// constants and types shared by the ancillary packet framer
package vbf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_FIFO = 8'h08;
    localparam logic [7:0] OFS_IRQ = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;

    localparam int CTRL_FIFO_BIT = 0;
    localparam int CTRL_ANC_BIT = 1;
    localparam int CTRL_RAW_BIT = 2;
    localparam int CTRL_FLUSH_BIT = 3;
    localparam logic [2:0] CTRL_RST = 3'h3;

    localparam int STAT_BUSY_BIT = 12;
    localparam int EV_STORED = 0;
    localparam int EV_DROP = 1;
    localparam int EV_SENT = 2;
    localparam int EV_RAW = 3;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;

    // ------------------------------------------------------------
    // packet bytes
    // ------------------------------------------------------------
    localparam logic [7:0] PRE_ZERO = 8'h00;
    localparam logic [7:0] PRE_ONES = 8'hFF;
    localparam logic [7:0] DID_F1_VBI = 8'h91;
    localparam logic [7:0] DID_F1_LATE = 8'h53;
    localparam logic [7:0] DID_F2_VBI = 8'h55;
    localparam logic [7:0] DID_F2_LATE = 8'h97;
    localparam logic [7:0] RAW_DID = 8'h60;
    localparam logic [7:0] CLOSE_DID = 8'h15;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam logic [6:0] HDR_LEN = 7'h08;
    localparam logic [6:0] PRE_LAST = 7'h03;

    typedef struct packed {
        logic [9:0] line;
        logic second_field;
        logic late_line;
        logic [5:0] fmt;
        logic match1;
        logic match2;
        logic err;
    } vbf_hdr_t;

    typedef enum {
        ST_IDLE, ST_CAPT, ST_FIFO, ST_WAITHB, ST_SEND, ST_RAWPRE, ST_RAW, ST_RAWPOST
    } vbf_state_t;

endpackage

// ==== vbf_framer.sv ====
// ancillary packet framer: sliced line data to packets, fifo and stream insertion
// Notes on behaviour
// - sliced packet goes out on the luma byte in the blanking after its line
// - fifo holds 512 bytes, same packet layout as the stream
// - every packet opens with 00h FFh FFh then the identifier byte
// - first field identifier: 91h vbi lines, 53h line 24 onwards
// - second field identifier: 55h vbi lines, 97h line 24 onwards
// - format, word count and checksum bytes carry even parity in bit 6, inverse in bit 7
// - format byte low six bits hold the line's service setting
// - word count gives four-byte words from byte 8 through last fill byte
// - byte 6 holds line number bits 7:0, byte 7 bits 1:0 hold bits 9:8
// - byte 7: bit 2 filter 2, bit 3 filter 1, bit 4 error, rest zero
// - checksum low six bits: sum from identifier byte through last payload
// - zero fill after checksum up to a multiple of four bytes
// - teletext sync byte is payload byte 8, data from byte 9
// - raw mode sends converter samples during the active line
// - raw block preamble ends with 60h
// - raw block closes with 00h FFh FFh 15h
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module vbf_framer
    import vbf_pkg::*;
#(
    parameter int FIFO_DEPTH = 512,
    parameter int MAX_PAYLOAD = 56,
    parameter int RAW_LEN = 1440
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    input wire vbf_hdr_t SLICE_HDR,
    input wire logic SLICE_START,
    input wire logic SLICE_VALID,
    input wire logic [7:0] SLICE_DATA,
    input wire logic SLICE_END,
    input wire logic HBLANK,
    input wire logic ACTIVE,
    input wire logic [7:0] RAW_SAMPLE,
    output logic [7:0] ANC_Y,
    output logic ANC_VALID
);

    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int RW = $clog2(RAW_LEN + 1);

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    function automatic logic [7:0] par6(input logic [5:0] v);
        par6 = {~(^v), ^v, v};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vbf_state_t st_reg, st_next;
    vbf_hdr_t hdr_reg, hdr_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [7:0] sum_reg, sum_next;
    logic [6:0] idx_reg, idx_next;
    logic [RW-1:0] raw_reg, raw_next;
    logic hb_prev_reg, act_prev_reg;
    logic [7:0] y_reg, y_next;
    logic yv_reg, yv_next;
    logic [7:0] line_buf [0:MAX_PAYLOAD-1];
    logic [7:0] fifo_mem [0:FIFO_DEPTH-1];
    logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [PW:0] fcnt_reg, fcnt_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [3:0] irq_reg, irq_next, mask_reg, mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [3:0] ev;
    logic [7:0] pb, data_identifier, flags, csum;
    logic [5:0] nw, cnt_in;
    logic [7:0] tot, need;
    logic [6:0] ck_idx;
    logic fits, push, pop, flush, hb_rise, act_rise;

    // ------------------------------------------------------------
    // packet byte generator
    // ------------------------------------------------------------
    always_comb begin
        case ({hdr_reg.second_field, hdr_reg.late_line})
            2'b00: data_identifier = DID_F1_VBI;
            2'b01: data_identifier = DID_F1_LATE;
            2'b10: data_identifier = DID_F2_VBI;
            default: data_identifier = DID_F2_LATE;
        endcase
        flags = {3'h0, hdr_reg.err, hdr_reg.match1, hdr_reg.match2, hdr_reg.line[9:8]};
        nw = 6'((7'(cnt_reg) + 7'h04) >> 2);
        tot = {2'h0, nw} * 8'h04 + 8'(HDR_LEN);
        ck_idx = HDR_LEN + 7'(cnt_reg);
        // room check counts a last byte that arrives together with the end strobe
        cnt_in = cnt_reg + 6'(SLICE_VALID && 32'(cnt_reg) < MAX_PAYLOAD);
        need = {2'h0, 6'((7'(cnt_in) + 7'h04) >> 2)} * 8'h04 + 8'(HDR_LEN);
        csum = data_identifier + par6(hdr_reg.fmt) + par6(nw) + hdr_reg.line[7:0] + flags + sum_reg;
    end

    always_comb begin
        pb = FILL_BYTE;
        case (idx_reg)
            7'h00: pb = PRE_ZERO;
            7'h01, 7'h02: pb = PRE_ONES;
            7'h03: pb = data_identifier;
            7'h04: pb = par6(hdr_reg.fmt);
            7'h05: pb = par6(nw);
            7'h06: pb = hdr_reg.line[7:0];
            7'h07: pb = flags;
            default: begin
                if (idx_reg < ck_idx) begin
                    // first payload byte is the teletext sync byte
                    pb = line_buf[6'(idx_reg - HDR_LEN)];
                end else if (idx_reg == ck_idx) begin
                    pb = par6(csum[5:0]);
                end else begin
                    pb = FILL_BYTE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    assign fits = (PW+2)'(FIFO_DEPTH) - {1'b0, fcnt_reg} >= (PW+2)'(need);
    assign hb_rise = HBLANK && !hb_prev_reg;
    assign act_rise = ACTIVE && !act_prev_reg;

    always_comb begin
        st_next = st_reg;
        hdr_next = hdr_reg;
        cnt_next = cnt_reg;
        sum_next = sum_reg;
        idx_next = idx_reg;
        raw_next = raw_reg;
        y_next = FILL_BYTE;
        yv_next = 1'b0;
        ev = 4'h0;
        case (st_reg)
            ST_IDLE: begin
                idx_next = 7'h00;
                if (SLICE_START) begin
                    hdr_next = SLICE_HDR;
                    cnt_next = 6'h00;
                    sum_next = 8'h00;
                    st_next = ST_CAPT;
                end else if (ctrl_reg[CTRL_RAW_BIT] && act_rise) begin
                    st_next = ST_RAWPRE;
                end
            end
            ST_CAPT: begin
                if (SLICE_VALID && 32'(cnt_reg) < MAX_PAYLOAD) begin
                    cnt_next = cnt_reg + 6'h01;
                    sum_next = sum_reg + SLICE_DATA;
                end
                if (SLICE_END) begin
                    if (ctrl_reg[CTRL_FIFO_BIT] && fits) begin
                        st_next = ST_FIFO;
                    end else begin
                        ev[EV_DROP] = ctrl_reg[CTRL_FIFO_BIT];
                        st_next = ctrl_reg[CTRL_ANC_BIT] ? ST_WAITHB : ST_IDLE;
                    end
                end
            end
            ST_FIFO: begin
                idx_next = idx_reg + 7'h01;
                if (8'(idx_reg) == tot - 8'h01) begin
                    idx_next = 7'h00;
                    ev[EV_STORED] = 1'b1;
                    st_next = ctrl_reg[CTRL_ANC_BIT] ? ST_WAITHB : ST_IDLE;
                end
            end
            ST_WAITHB: begin
                if (hb_rise) begin
                    st_next = ST_SEND;
                end
            end
            ST_SEND: begin
                y_next = pb;
                yv_next = 1'b1;
                idx_next = idx_reg + 7'h01;
                if (8'(idx_reg) == tot - 8'h01) begin
                    ev[EV_SENT] = 1'b1;
                    st_next = ST_IDLE;
                end
            end
            ST_RAWPRE: begin
                y_next = (idx_reg == PRE_LAST) ? RAW_DID : pb;
                yv_next = 1'b1;
                idx_next = idx_reg + 7'h01;
                if (idx_reg == PRE_LAST) begin
                    idx_next = 7'h00;
                    raw_next = RW'(RAW_LEN);
                    st_next = ST_RAW;
                end
            end
            ST_RAW: begin
                y_next = RAW_SAMPLE;
                yv_next = 1'b1;
                raw_next = raw_reg - RW'(1);
                if (raw_reg == RW'(1)) begin
                    st_next = ST_RAWPOST;
                end
            end
            ST_RAWPOST: begin
                y_next = (idx_reg == PRE_LAST) ? CLOSE_DID : pb;
                yv_next = 1'b1;
                idx_next = idx_reg + 7'h01;
                if (idx_reg == PRE_LAST) begin
                    idx_next = 7'h00;
                    ev[EV_RAW] = 1'b1;
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_reg <= ST_IDLE;
            hdr_reg <= '0;
            cnt_reg <= 6'h00;
            sum_reg <= 8'h00;
            idx_reg <= 7'h00;
            raw_reg <= '0;
            hb_prev_reg <= 1'b0;
            act_prev_reg <= 1'b0;
            y_reg <= 8'h00;
            yv_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            hdr_reg <= hdr_next;
            cnt_reg <= cnt_next;
            sum_reg <= sum_next;
            idx_reg <= idx_next;
            raw_reg <= raw_next;
            hb_prev_reg <= HBLANK;
            act_prev_reg <= ACTIVE;
            y_reg <= y_next;
            yv_reg <= yv_next;
        end
    end

    // line buffer, no reset needed
    always_ff @(posedge CLK) begin
        if (st_reg == ST_CAPT && SLICE_VALID && 32'(cnt_reg) < MAX_PAYLOAD) begin
            line_buf[cnt_reg] <= SLICE_DATA;
        end
    end

    assign ANC_Y = y_reg;
    assign ANC_VALID = yv_reg;

    // ------------------------------------------------------------
    // packet fifo
    // ------------------------------------------------------------
    assign push = (st_reg == ST_FIFO);
    assign pop = RD && ADDR == OFS_FIFO && fcnt_reg != '0;
    assign flush = WR && ADDR == OFS_CTRL && WDATA[CTRL_FLUSH_BIT];

    always_comb begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        fcnt_next = fcnt_reg;
        if (flush) begin
            wp_next = '0;
            rp_next = '0;
            fcnt_next = '0;
        end else begin
            if (push) begin
                wp_next = wp_reg + PW'(1);
            end
            if (pop) begin
                rp_next = rp_reg + PW'(1);
            end
            fcnt_next = fcnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wp_reg <= '0;
            rp_reg <= '0;
            fcnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            fcnt_reg <= fcnt_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (push) begin
            fifo_mem[wp_reg] <= pb;
        end
    end

    // ------------------------------------------------------------
    // register port and interrupt
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        irq_next = irq_reg;
        rdata_next = 32'h0000_0000;
        if (WR && ADDR == OFS_CTRL) begin
            ctrl_next = WDATA[2:0];
        end
        if (WR && ADDR == OFS_MASK) begin
            mask_next = WDATA[3:0];
        end
        if (WR && ADDR == OFS_IRQ) begin
            irq_next = irq_reg & ~WDATA[3:0];
        end
        // new event wins over a clear in the same cycle
        irq_next = irq_next | ev;
        if (RD) begin
            case (ADDR)
                OFS_CTRL: rdata_next = {29'h0, ctrl_reg};
                OFS_STAT: rdata_next = {19'h0, st_reg != ST_IDLE, 12'(fcnt_reg)};
                OFS_FIFO: rdata_next = pop ? {24'h0, fifo_mem[rp_reg]} : 32'h0000_0000;
                OFS_IRQ: rdata_next = {28'h0, irq_reg};
                OFS_MASK: rdata_next = {28'h0, mask_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_reg <= CTRL_RST;
            mask_reg <= MASK_RST;
            irq_reg <= IRQ_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign RDATA = rdata_reg;
    assign IRQ = |(irq_reg & mask_reg);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_preamble_seq: assert property (
        (st_reg == ST_SEND && idx_reg == 7'h00) |=> ANC_Y == PRE_ZERO ##1 ANC_Y == PRE_ONES
            ##1 ANC_Y == PRE_ONES ##1 ANC_Y == data_identifier)
        else $error("packet preamble wrong");
    a_did_value: assert property (
        (st_reg == ST_SEND && idx_reg == PRE_LAST) |=> ANC_Y[5:3] == 3'b010
            && ANC_Y == (hdr_reg.second_field ? (hdr_reg.late_line ? 8'h97 : 8'h55)
                : (hdr_reg.late_line ? 8'h53 : 8'h91)))
        else $error("identifier byte wrong");
    a_hdr_parity: assert property (
        (st_reg == ST_SEND && (idx_reg == 7'h04 || idx_reg == 7'h05 || idx_reg == ck_idx))
            |=> ANC_Y[6] == ^ANC_Y[5:0] && ANC_Y[7] != ANC_Y[6])
        else $error("parity bits wrong");
    a_fmt_code: assert property (
        (st_reg == ST_SEND && idx_reg == 7'h04) |=> ANC_Y[5:0] == $past(hdr_reg.fmt))
        else $error("format code wrong");
    a_word_count: assert property (
        (st_reg == ST_SEND && idx_reg == 7'h05)
            |=> {ANC_Y[5:0], 2'b00} >= $past(cnt_reg) + 8'h01
            && {ANC_Y[5:0], 2'b00} <= $past(cnt_reg) + 8'h04)
        else $error("word count wrong");
    a_line_flags: assert property (
        (st_reg == ST_SEND && idx_reg == 7'h07) |=> ANC_Y[7:5] == 3'b000
            && ANC_Y[1:0] == hdr_reg.line[9:8] && ANC_Y[4] == hdr_reg.err
            && ANC_Y[3] == hdr_reg.match1 && ANC_Y[2] == hdr_reg.match2)
        else $error("line flags byte wrong");
    a_fill_zero: assert property (
        (st_reg == ST_SEND && idx_reg > ck_idx) |=> ANC_Y == FILL_BYTE)
        else $error("fill byte not zero");
    a_hb_wait: assert property (
        (st_reg == ST_WAITHB && !hb_rise) |=> !ANC_VALID)
        else $error("packet sent outside blanking");
    a_raw_open: assert property (
        (st_reg == ST_RAWPRE && idx_reg == PRE_LAST) |=> ANC_Y == 8'h60 && ANC_VALID)
        else $error("raw preamble wrong");
    a_raw_close: assert property (
        (st_reg == ST_RAW && raw_reg == RW'(1)) |=> ##1 ANC_Y == 8'h00 ##1 ANC_Y == 8'hFF
            ##1 ANC_Y == 8'hFF ##1 ANC_Y == 8'h15)
        else $error("raw closing preamble wrong");
    a_no_trunc: assert property (
        (st_reg == ST_CAPT && SLICE_END && !fits)
            |=> st_reg != ST_FIFO && fcnt_reg <= $past(fcnt_reg))
        else $error("packet stored without room");
    a_fifo_bound: assert property (
        fcnt_reg <= (PW+1)'(FIFO_DEPTH))
        else $error("fifo count overflow");

    c_drop: cover property (st_reg == ST_CAPT && SLICE_END && ctrl_reg[CTRL_FIFO_BIT] && !fits);
    c_sent: cover property (ev[EV_SENT]);
    c_raw: cover property (ev[EV_RAW]);
    c_pop: cover property (pop);

endmodule

// ==== vbf_rx_model.sv ====
// downstream stream receiver model: collects inserted ancillary bytes
`timescale 1ns/1ps
module vbf_rx_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] anc_y,
    input wire logic anc_valid,
    input wire logic hblank,
    input wire logic active
);
    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    logic [7:0] got_q[$];
    int bursts = 0;
    int stray = 0;
    logic valid_reg = 1'b0;

    // a new burst starts on each rising edge of the valid flag
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= anc_valid;
            if (anc_valid === 1'b1) begin
                got_q.push_back(anc_y);
                if (valid_reg !== 1'b1) begin
                    bursts++;
                end
                // bytes only belong in blanking or in the active line
                if (hblank !== 1'b1 && active !== 1'b1) begin
                    stray++;
                end
            end
        end
    end
endmodule

// ==== tb_vbf_framer.sv ====
// self-checking bench for the ancillary packet framer
`timescale 1ns/1ps
module tb_vbf_framer;
    import vbf_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int DEPTH = 64;
    localparam int MAXP = 40;
    localparam int RLEN = 8;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    logic IRQ;
    vbf_hdr_t SLICE_HDR = '0;
    logic SLICE_START = 1'b0;
    logic SLICE_VALID = 1'b0;
    logic [7:0] SLICE_DATA = 8'h00;
    logic SLICE_END = 1'b0;
    logic HBLANK = 1'b0;
    logic ACTIVE = 1'b0;
    logic [7:0] RAW_SAMPLE = 8'h00;
    logic [7:0] ANC_Y;
    logic ANC_VALID;
    int miscompares = 0;
    int num_checks = 0;
    int seed = 32'h6544;
    int i;
    int base;
    logic [7:0] exp_q[$];
    logic [7:0] keep_q[$];
    logic [31:0] rv;
    vbf_hdr_t h;

    always #10 CLK = ~CLK;

    vbf_framer #(.FIFO_DEPTH(DEPTH), .MAX_PAYLOAD(MAXP), .RAW_LEN(RLEN)) vbf_framer_i (
        .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IRQ(IRQ), .SLICE_HDR(SLICE_HDR), .SLICE_START(SLICE_START),
        .SLICE_VALID(SLICE_VALID), .SLICE_DATA(SLICE_DATA), .SLICE_END(SLICE_END),
        .HBLANK(HBLANK), .ACTIVE(ACTIVE), .RAW_SAMPLE(RAW_SAMPLE), .ANC_Y(ANC_Y),
        .ANC_VALID(ANC_VALID)
    );

    vbf_rx_model vbf_rx_model_i (
        .clk(CLK), .nrst(NRST), .anc_y(ANC_Y), .anc_valid(ANC_VALID),
        .hblank(HBLANK), .active(ACTIVE)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic wait_rx(input int want);
        int t;
        for (t = 0; t < 4000 && vbf_rx_model_i.got_q.size() < want; t++) begin
            @(posedge CLK);
        end
        if (vbf_rx_model_i.got_q.size() < want) begin
            miscompares++;
            $display("BAD stream wait exp %0d seen %0d", want, vbf_rx_model_i.got_q.size());
            end_sim();
        end
    endtask

    function automatic logic [7:0] par(input logic [5:0] v);
        return {~(^v), ^v, v};
    endfunction

    // expected packet built from the header and payload, then sent and compared
    task automatic run_pkt(input vbf_hdr_t hd, input int n, input bit drain);
        logic [7:0] pl[$];
        logic [7:0] dids[4];
        logic [7:0] sum;
        logic [31:0] g;
        logic [31:0] e;
        int tot;
        int b0;
        int nb;
        int k;
        dids = '{8'h91, 8'h53, 8'h55, 8'h97};
        tot = 8 + 4 * ((n + 4) / 4);
        exp_q = '{8'h00, 8'hFF, 8'hFF, dids[{hd.second_field, hd.late_line}], par(hd.fmt),
            par(6'((tot - 8) / 4)), hd.line[7:0],
            {3'b000, hd.err, hd.match1, hd.match2, hd.line[9:8]}};
        for (k = 0; k < n; k++) begin
            pl.push_back(8'($random(seed)));
            exp_q.push_back(pl[k]);
        end
        sum = 8'h00;
        for (k = 3; k < exp_q.size(); k++) begin
            sum = sum + exp_q[k];
        end
        exp_q.push_back(par(sum[5:0]));
        while (exp_q.size() < tot) begin
            exp_q.push_back(8'h00);
        end
        @(posedge CLK);
        SLICE_HDR <= hd;
        SLICE_START <= 1'b1;
        for (k = 0; k < n; k++) begin
            @(posedge CLK);
            SLICE_START <= 1'b0;
            SLICE_VALID <= 1'b1;
            SLICE_DATA <= pl[k];
        end
        @(posedge CLK);
        SLICE_VALID <= 1'b0;
        SLICE_END <= 1'b1;
        @(posedge CLK);
        SLICE_END <= 1'b0;
        repeat (tot + 4) @(posedge CLK);
        b0 = vbf_rx_model_i.got_q.size();
        nb = vbf_rx_model_i.bursts;
        HBLANK <= 1'b1;
        wait_rx(b0 + tot);
        HBLANK <= 1'b0;
        for (k = 0; k < tot; k++) begin
            g = {24'h0, vbf_rx_model_i.got_q[b0 + k]};
            e = {24'h0, exp_q[k]};
            if (k < 8) begin
                check("header byte", g, e);
            end else begin
                check("body byte", g, e);
            end
        end
        check("burst count", vbf_rx_model_i.bursts, nb + 1);
        repeat (4) @(posedge CLK);
        check("stream length", vbf_rx_model_i.got_q.size(), b0 + tot);
        if (drain) begin
            rd(OFS_STAT, rv);
            check("fifo count", {22'h0, rv[9:0]}, tot);
            for (k = 0; k < tot; k++) begin
                rd(OFS_FIFO, rv);
                check("fifo byte", rv, {24'h0, exp_q[k]});
            end
            rd(OFS_FIFO, rv);
            check("empty fifo read", rv, 32'h0);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        rd(OFS_CTRL, rv);
        check("ctrl reset", rv, 32'h3);
        rd(8'h40, rv);
        check("unmapped read", rv, 32'h0);
        // all four identifier cases, short, full and random payloads
        for (i = 0; i < 4; i++) begin
            h.line = 10'($random(seed));
            h.fmt = 6'($random(seed));
            {h.match1, h.match2, h.err} = 3'($random(seed));
            h.second_field = i[1];
            h.late_line = i[0];
            run_pkt(h, (i == 0) ? 3 : (i == 1) ? MAXP : 1 + int'({$random(seed)} % MAXP), 1'b1);
            if (i == 0) begin
                rd(OFS_IRQ, rv);
                check("events", {28'h0, rv[3:0]}, 32'h5);
                check("irq masked", {31'h0, IRQ}, 32'h0);
                wr(OFS_MASK, 32'h4);
                #1;
                check("irq on", {31'h0, IRQ}, 32'h1);
                wr(OFS_IRQ, 32'h4);
                #1;
                check("irq cleared", {31'h0, IRQ}, 32'h0);
                wr(OFS_IRQ, 32'hF);
            end
        end
        // second packet cannot fit behind the first
        run_pkt(h, MAXP, 1'b0);
        keep_q = exp_q;
        run_pkt(h, MAXP, 1'b0);
        rd(OFS_STAT, rv);
        check("count after drop", {22'h0, rv[9:0]}, keep_q.size());
        rd(OFS_IRQ, rv);
        check("drop event", {28'h0, rv[3:0]}, 32'h7);
        for (i = 0; i < keep_q.size(); i++) begin
            rd(OFS_FIFO, rv);
            check("kept byte", rv, {24'h0, keep_q[i]});
        end
        // flush empties a fifo holding one short packet
        run_pkt(h, 3, 1'b0);
        wr(OFS_CTRL, 32'hB);
        rd(OFS_STAT, rv);
        check("count after flush", {22'h0, rv[9:0]}, 32'h0);
        rd(OFS_CTRL, rv);
        check("ctrl after flush", rv, 32'h3);
        // raw block in the active line
        wr(OFS_IRQ, 32'hF);
        wr(OFS_CTRL, 32'h7);
        RAW_SAMPLE <= 8'($random(seed));
        repeat (2) @(posedge CLK);
        exp_q = '{8'h00, 8'hFF, 8'hFF, 8'h60};
        repeat (RLEN) exp_q.push_back(RAW_SAMPLE);
        exp_q = {exp_q, 8'h00, 8'hFF, 8'hFF, 8'h15};
        base = vbf_rx_model_i.got_q.size();
        ACTIVE <= 1'b1;
        wait_rx(base + RLEN + 8);
        ACTIVE <= 1'b0;
        for (i = 0; i < RLEN + 8; i++) begin
            check("raw byte", vbf_rx_model_i.got_q[base + i], exp_q[i]);
        end
        rd(OFS_IRQ, rv);
        check("raw event", {28'h0, rv[3:0]}, 32'h8);
        check("bytes outside window", vbf_rx_model_i.stray, 0);
        end_sim();
    end
endmodule
